// ### hw/cwsc_watchdog.sv
// module: communications watchdog and station configuration
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - station address is 08 hex plus four switch bits, sixteen addresses
// - a switch in the on position reads as one
// - watchdog supervises only if switch 5 was on at startup
// - elapsed time beyond the timeout starts the alarm sequence
// - host writing minus one disables the watchdog
// - after disable, a valid timeout write re-arms it
// - timeout accepted from 1 to 1092 seconds, one second steps
// - timeout is two bytes at 0290 and 0291 hex, host writable
// - timeout is 120 seconds after reset
// - expiry sets every control output type to manual
// - expiry forces every control output value to zero
// - expiry turns on dedicated digital output 72
// - expiry sets the internal reset flag
// - switch 6 picks baud: off 2400, on 9600
// - switch 7 picks check: off block check, on cyclic redundancy
// - up to sixteen controllers share one line by address
// - packets follow the serial protocol and character set in use
module cwsc_watchdog
   import cwsc_pkg::*;
#(
   parameter int TICK_CYCLES = cwsc_pkg::CWSC_TICK_CYCLES,
   parameter int OUT_COUNT = cwsc_pkg::CWSC_OUT_COUNT
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration switch pins, bit 0 is switch 1, on is high
   input wire logic [7:0] cfg_switch,
   // from the packet decoder, same clock
   input wire logic pkt_valid,
   input wire logic [7:0] pkt_station,
   input wire cwsc_pkg::cwsc_wr_t tbl_wr,
   input wire logic [15:0] tbl_rd_addr,
   input wire logic reset_flag_clr,
   // to the rest of the controller
   output var cwsc_pkg::cwsc_cfg_t cfg,
   output logic [7:0] tbl_rd_data,
   output logic [OUT_COUNT-1:0] force_manual,
   output logic [OUT_COUNT-1:0] force_zero,
   output logic [7:0] forced_value,
   output logic dout_timeout,
   output logic reset_flag,
   output logic wdog_active
);
   import cwsc_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);

   // ----------------------------------------
   // switch synchroniser and capture
   // ----------------------------------------
   logic [7:0] sw_meta_q;
   logic [7:0] sw_sync_q;
   logic [1:0] cap_q;
   cwsc_cfg_t cfg_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sw_meta_q <= 8'h00;
         sw_sync_q <= 8'h00;
      end
      else
      begin
         sw_meta_q <= cfg_switch;
         sw_sync_q <= sw_meta_q;
      end
   end

   // capture waits for the synchroniser to settle after release
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_q <= 2'b00;
         cfg_q <= '0;
      end
      else if (cap_q != 2'b11)
      begin
         cap_q <= cap_q + 2'b01;
         if (cap_q == 2'b10)
         begin
            cfg_q.station_address <= CWSC_STN_BASE + {4'h0, sw_sync_q[3:0]};
            cfg_q.wdog_hw_en <= sw_sync_q[CWSC_SW_WDOG];
            cfg_q.baud_9600 <= sw_sync_q[CWSC_SW_BAUD];
            cfg_q.check_crc <= sw_sync_q[CWSC_SW_CHECK];
         end
      end
   end

   logic cfg_ready;
   assign cfg_ready = (cap_q == 2'b11);
   assign cfg = cfg_q;

   // ----------------------------------------
   // timeout period table
   // ----------------------------------------
   logic [15:0] tmo_q;
   logic [7:0] hold_a_q;
   logic sw_en_q;
   logic wr_a;
   logic wr_b;
   logic [15:0] new_tmo;
   logic new_valid;

   // byte a is the high byte; the word takes effect on the byte b write
   assign wr_a = tbl_wr.we && (tbl_wr.addr == CWSC_TMO_ADDR_A);
   assign wr_b = tbl_wr.we && (tbl_wr.addr == CWSC_TMO_ADDR_B);
   assign new_tmo = {hold_a_q, tbl_wr.data};
   assign new_valid = (new_tmo >= CWSC_TMO_MIN) && (new_tmo <= CWSC_TMO_MAX);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_a_q <= CWSC_TMO_DEFAULT[15:8];
         tmo_q <= CWSC_TMO_DEFAULT;
         sw_en_q <= 1'b1;
      end
      else
      begin
         if (wr_a)
         begin
            hold_a_q <= tbl_wr.data;
         end
         if (wr_b && new_tmo == CWSC_TMO_DISABLE)
         begin
            tmo_q <= new_tmo;
            sw_en_q <= 1'b0;
         end
         else if (wr_b && new_valid)
         begin
            tmo_q <= new_tmo;
            sw_en_q <= 1'b1;
         end
      end
   end

   always_comb
   begin
      tbl_rd_data = 8'h00;
      if (tbl_rd_addr == CWSC_TMO_ADDR_A)
      begin
         tbl_rd_data = tmo_q[15:8];
      end
      else if (tbl_rd_addr == CWSC_TMO_ADDR_B)
      begin
         tbl_rd_data = tmo_q[7:0];
      end
   end

   // ----------------------------------------
   // second tick and elapsed counter
   // ----------------------------------------
   logic [TW-1:0] div_q;
   logic tick;
   logic [15:0] elapsed_q;
   logic contact;
   logic active;
   cwsc_state_t state_q;

   assign contact = pkt_valid && (pkt_station == cfg_q.station_address);
   assign active = cfg_ready && cfg_q.wdog_hw_en && sw_en_q;
   assign tick = (div_q == TW'(TICK_CYCLES - 1));
   assign wdog_active = active;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_q <= '0;
      else if (!active || contact || tick)
         div_q <= '0;
      else
         div_q <= div_q + TW'(1);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         elapsed_q <= 16'h0000;
      else if (!active || contact)
         elapsed_q <= 16'h0000;
      else if (tick && elapsed_q != CWSC_TMO_DISABLE)
         elapsed_q <= elapsed_q + 16'h0001;
   end

   // ----------------------------------------
   // alarm state
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= CWSC_ST_IDLE;
      end
      else
      begin
         case (state_q)
            CWSC_ST_IDLE:
            begin
               if (active)
               begin
                  state_q <= CWSC_ST_RUN;
               end
            end
            CWSC_ST_RUN:
            begin
               if (!active)
               begin
                  state_q <= CWSC_ST_IDLE;
               end
               else if (elapsed_q > tmo_q && !contact)
               begin
                  state_q <= CWSC_ST_EXPIRED;
               end
            end
            CWSC_ST_EXPIRED:
            begin
               // outputs stay safe until the host talks again or the watchdog goes inactive
               if (contact || !active)
               begin
                  state_q <= active ? CWSC_ST_RUN : CWSC_ST_IDLE;
               end
            end
            default:
            begin
               state_q <= CWSC_ST_IDLE;
            end
         endcase
      end
   end

   logic expired;
   assign expired = (state_q == CWSC_ST_EXPIRED);

   // the per-output forcing is replicated so each channel has its own flop
   genvar gi;
   generate
      for (gi = 0; gi < OUT_COUNT; gi++)
      begin : g_out
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               force_manual[gi] <= 1'b0;
               force_zero[gi] <= 1'b0;
            end
            else
            begin
               force_manual[gi] <= expired;
               force_zero[gi] <= expired;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dout_timeout <= 1'b0;
         forced_value <= CWSC_OUT_ZERO;
      end
      else
      begin
         dout_timeout <= expired;
         forced_value <= CWSC_OUT_ZERO;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         reset_flag <= 1'b1;
      else if (expired)
         reset_flag <= 1'b1;
      else if (reset_flag_clr)
         reset_flag <= 1'b0;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_expire;
      state_q == CWSC_ST_RUN && elapsed_q > tmo_q && !contact && active;
   endsequence

   a_expire_outputs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_expire |=> ##1 (force_manual == {OUT_COUNT{1'b1}} && force_zero == {OUT_COUNT{1'b1}}))
      else $error("outputs not forced after expiry");
   a_expire_dout: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_expire |=> ##1 dout_timeout)
      else $error("timeout output not set");
   a_expire_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_expire |=> ##1 reset_flag)
      else $error("reset flag not set on expiry");
   a_zero_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
      dout_timeout |-> force_zero == {OUT_COUNT{1'b1}} && forced_value == CWSC_OUT_ZERO)
      else $error("forced value not zero");
   a_no_hw_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_ready && !cfg_q.wdog_hw_en |-> state_q == CWSC_ST_IDLE && !dout_timeout)
      else $error("watchdog ran with switch off");
   a_sw_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_b && new_tmo == CWSC_TMO_DISABLE |=> !wdog_active ##1 state_q != CWSC_ST_RUN)
      else $error("minus one did not disable");
   a_rearm: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_b && new_valid |=> sw_en_q && tmo_q == $past(new_tmo))
      else $error("valid write did not rearm");
   a_bad_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_b && !new_valid && new_tmo != CWSC_TMO_DISABLE |=> $stable(tmo_q) && $stable(sw_en_q))
      else $error("out of range timeout accepted");
   a_station: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_ready |-> cfg_q.station_address >= CWSC_STN_BASE
      && cfg_q.station_address < CWSC_STN_BASE + 8'(CWSC_STATIONS))
      else $error("station address out of range");
   a_contact_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      active && contact |=> elapsed_q == 16'h0000)
      else $error("contact did not restart count");
   a_cfg_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_ready && $past(cfg_ready) |-> $stable(cfg_q))
      else $error("configuration changed after capture");
endmodule : cwsc_watchdog
`default_nettype wire

// ### inc/cwsc_pkg.sv
// package: constants and types of the communications watchdog and station config
package cwsc_pkg;
   // data table locations of the timeout period
   localparam logic [15:0] CWSC_TMO_ADDR_A = 16'h0290;
   localparam logic [15:0] CWSC_TMO_ADDR_B = 16'h0291;
   // station addressing
   localparam logic [7:0] CWSC_STN_BASE = 8'h08;
   localparam int CWSC_STATIONS = 16;
   // timeout period limits in seconds
   localparam logic [15:0] CWSC_TMO_DEFAULT = 16'h0078;
   localparam logic [15:0] CWSC_TMO_MIN = 16'h0001;
   localparam logic [15:0] CWSC_TMO_MAX = 16'h0444;
   localparam logic [15:0] CWSC_TMO_DISABLE = 16'hFFFF;
   // clock and tick
   localparam int CWSC_CLK_HZ = 200_000_000;
   localparam int CWSC_TICK_S = 1;
   localparam int CWSC_TICK_CYCLES = CWSC_CLK_HZ * CWSC_TICK_S;
   // switch positions, zero based
   localparam int CWSC_SW_WDOG = 4;
   localparam int CWSC_SW_BAUD = 5;
   localparam int CWSC_SW_CHECK = 6;
   // dedicated timeout digital output number
   localparam int CWSC_DOUT_TIMEOUT = 72;
   localparam int CWSC_OUT_COUNT = 32;
   localparam logic [7:0] CWSC_OUT_ZERO = 8'h00;

   typedef enum logic [1:0]
   {
      CWSC_ST_IDLE = 2'b00,
      CWSC_ST_RUN = 2'b01,
      CWSC_ST_EXPIRED = 2'b10
   } cwsc_state_t;

   // configuration captured from the switches
   typedef struct packed
   {
      logic [7:0] station_address;
      logic wdog_hw_en;
      logic baud_9600;
      logic check_crc;
   } cwsc_cfg_t;

   // host data table write
   typedef struct packed
   {
      logic we;
      logic [15:0] addr;
      logic [7:0] data;
   } cwsc_wr_t;
endpackage : cwsc_pkg

// ### testbench/cwsc_host_model.sv
// host model: packet pulses and timeout writes toward the watchdog
`timescale 1ns/10ps
`default_nettype none
module cwsc_host_model
   import cwsc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // toward the device
   output logic pkt_valid,
   output logic [7:0] pkt_station,
   output var cwsc_pkg::cwsc_wr_t tbl_wr
);
   import cwsc_pkg::*;

   initial
   begin
      pkt_valid = 1'b0;
      pkt_station = 8'h00;
      tbl_wr = '0;
   end

   // one packet addressed to a station; released lines show the inverse
   task automatic pkt(input logic [7:0] st);
      @(negedge ref_clk);
      pkt_valid = 1'b1;
      pkt_station = st;
      @(negedge ref_clk);
      pkt_valid = 1'b0;
      pkt_station = ~st;
   endtask : pkt

   // high byte first, low byte makes the word take effect
   task automatic wr(input logic [15:0] w);
      @(negedge ref_clk);
      tbl_wr = {1'b1, CWSC_TMO_ADDR_A, w[15:8]};
      @(negedge ref_clk);
      tbl_wr = {1'b1, CWSC_TMO_ADDR_B, w[7:0]};
      @(negedge ref_clk);
      tbl_wr = {1'b0, ~CWSC_TMO_ADDR_B, ~w[7:0]};
   endtask : wr
endmodule : cwsc_host_model
`default_nettype wire

// ### testbench/tb.sv
// testbench of the communications watchdog and station configuration
`timescale 1ns/10ps
`default_nettype none
module tb;
   import cwsc_pkg::*;
   // short tick keeps whole-second timeouts cheap
   localparam int TK = 10;
   logic ref_clk, rst_n, reset_flag_clr, pkt_valid, dout_timeout, reset_flag, wdog_active;
   logic [7:0] cfg_switch, pkt_station, tbl_rd_data, forced_value;
   logic [15:0] tbl_rd_addr;
   logic [31:0] force_manual, force_zero;
   cwsc_wr_t tbl_wr;
   cwsc_cfg_t cfg;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   logic [7:0] sw_row [5] = '{8'h00, 8'h0F, 8'h15, 8'h6A, 8'h93};
   cwsc_cfg_t cfg_row [5] = '{{8'h08, 3'b000}, {8'h17, 3'b000}, {8'h0D, 3'b100},
      {8'h12, 3'b011}, {8'h0B, 3'b100}};

   cwsc_watchdog #(.TICK_CYCLES(TK)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .cfg_switch(cfg_switch), .pkt_valid(pkt_valid), .pkt_station(pkt_station),
      .tbl_wr(tbl_wr), .tbl_rd_addr(tbl_rd_addr), .reset_flag_clr(reset_flag_clr),
      .cfg(cfg), .tbl_rd_data(tbl_rd_data), .force_manual(force_manual),
      .force_zero(force_zero), .forced_value(forced_value), .dout_timeout(dout_timeout),
      .reset_flag(reset_flag), .wdog_active(wdog_active));
   cwsc_host_model host_u (.ref_clk(ref_clk), .pkt_valid(pkt_valid),
      .pkt_station(pkt_station), .tbl_wr(tbl_wr));

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // switches are only looked at while reset is released
   task automatic rst(input logic [7:0] sw);
      @(negedge ref_clk);
      rst_n = 1'b0;
      cfg_switch = sw;
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge ref_clk);
   endtask : rst

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      tbl_rd_addr = a;
      #1 chk(tbl_rd_data, exp);
   endtask : rd

   task automatic wexp(input int lim);
      n = 0;
      while (dout_timeout !== 1'b1 && n < lim)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask : wexp

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         results();
      end
   end

   initial
   begin
      rst_n = 1'b0;
      cfg_switch = 8'h00;
      tbl_rd_addr = 16'h0000;
      reset_flag_clr = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         rst(sw_row[i]);
         chk(cfg, cfg_row[i]);
      end
      rd(CWSC_TMO_ADDR_A, 8'h00);
      rd(CWSC_TMO_ADDR_B, 8'h78);
      rd(16'h0000, 8'h00);
      chk(reset_flag, 1'b1);
      @(negedge ref_clk);
      reset_flag_clr = 1'b1;
      @(negedge ref_clk);
      reset_flag_clr = 1'b0;
      chk(reset_flag, 1'b0);
      host_u.wr(16'h0001);
      rd(CWSC_TMO_ADDR_B, 8'h01);
      host_u.pkt(8'h0B);
      wexp(100);
      // more than one whole second passes before expiry, at most two seconds plus three cycles
      chk(n > TK && n <= 2 * TK + 3, 1'b1);
      #1 chk(force_manual, 32'hFFFF_FFFF);
      chk(force_zero, 32'hFFFF_FFFF);
      chk(forced_value, 8'h00);
      chk(reset_flag, 1'b1);
      host_u.pkt(8'h0C);
      repeat (3) @(negedge ref_clk);
      chk(dout_timeout, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         host_u.pkt(8'h0B);
         repeat (3) @(negedge ref_clk);
         chk({dout_timeout, force_manual[0], force_zero[31]}, 3'b000);
      end
      host_u.wr(16'hFFFF);
      chk(wdog_active, 1'b0);
      rd(CWSC_TMO_ADDR_A, 8'hFF);
      wexp(5 * TK);
      chk(dout_timeout, 1'b0);
      host_u.wr(16'h0445);
      rd(CWSC_TMO_ADDR_B, 8'hFF);
      host_u.wr(16'h0000);
      rd(CWSC_TMO_ADDR_B, 8'hFF);
      chk(wdog_active, 1'b0);
      host_u.wr(16'h0444);
      rd(CWSC_TMO_ADDR_A, 8'h04);
      rd(CWSC_TMO_ADDR_B, 8'h44);
      chk(wdog_active, 1'b1);
      // re-armed watchdog must supervise again
      host_u.wr(16'h0001);
      wexp(100);
      chk(dout_timeout, 1'b1);
      // a clear while expired loses against the set
      @(negedge ref_clk);
      reset_flag_clr = 1'b1;
      @(negedge ref_clk);
      reset_flag_clr = 1'b0;
      chk(reset_flag, 1'b1);
      cfg_switch = 8'h00;
      repeat (10) @(negedge ref_clk);
      chk(cfg, cfg_row[4]);
      rst(8'h0B);
      chk({dout_timeout, force_manual[0], reset_flag}, 3'b001);
      rd(CWSC_TMO_ADDR_B, 8'h78);
      host_u.wr(16'h0001);
      wexp(5 * TK);
      chk({dout_timeout, wdog_active}, 2'b00);
      results();
   end
endmodule : tb
`default_nettype wire
